// ### core/afe_pkg.sv
// Shared constants, register map and helpers of the AFE power and gain control.
package afe_pkg;

    // ==========================================================
    // Sizes
    localparam int CHANNELS = 4;
    localparam int SAMPLE_W = 16;
    localparam int DATA_W = 24;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_THERMO = 8'h0C;
    localparam logic [7:0] OFS_READY = 8'h10;
    localparam logic [7:0] OFS_DATA0 = 8'h20;
    localparam logic [7:0] OFS_RANGE0 = 8'h30;

    // ==========================================================
    // Field positions and reset values
    localparam int CFG_SHUTDOWN_LSB = 0;
    localparam int CFG_SOFT_RESET_LSB = 4;
    localparam int CFG_EXT_REF_BIT = 8;
    localparam int CFG_EXT_CLK_BIT = 9;
    localparam int CFG_W = 10;
    localparam int GAIN_W = 12;
    localparam logic [CFG_W-1:0] CONFIG_RESET = 10'h000;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h000;
    localparam int ST_FULL_SHUTDOWN = 0;
    localparam int ST_MONITORS = 1;
    localparam int ST_CORE_CLOCK = 2;
    localparam int ST_INPUT_CLOCK = 3;
    localparam int ST_INT_REF = 4;

    // ==========================================================
    // Modulator constants
    localparam logic [3:0] THERMO_DEFAULT = 4'h3;
    localparam logic [2:0] GAIN_MAX_CODE = 3'h5;
    localparam logic [19:0] RANGE_BASE_UV = 20'd600000;
    localparam logic signed [27:0] DAC_STEP = 28'sh0004000;
    localparam int OSR = 64;
    localparam int OSR_W = 6;

    // ==========================================================
    // Timing
    localparam int CLOCK_HZ = 20000000;
    localparam int SAMPLE_CLOCK_HZ = 1000000;
    localparam int SAMPLE_DIV = CLOCK_HZ / SAMPLE_CLOCK_HZ;
    localparam int SAMPLE_DIV_W = 5;

    // Undefined gain codes act as gain 1.
    function automatic logic [2:0] gain_shift(input logic [2:0] code);
        return (code > GAIN_MAX_CODE) ? 3'h0 : code;
    endfunction

    // Merges write data into a register under the APB byte strobes.
    function automatic logic [31:0] apply_strb(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] strb);
        logic [31:0] result;
        result = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                result[8*b +: 8] = new_word[8*b +: 8];
            end
        end
        return result;
    endfunction

endpackage

// ### core/afe_power_and_gain_control.sv
// APB-controlled power mode and gain control for a four-channel converter front end.
`timescale 1ns/1ps
module afe_power_and_gain_control (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [afe_pkg::CHANNELS*afe_pkg::SAMPLE_W-1:0] channel_sample,
    output logic [afe_pkg::CHANNELS*4-1:0] channel_thermo,
    output logic [afe_pkg::CHANNELS-1:0] channel_data_ready,
    output logic [afe_pkg::CHANNELS-1:0] channel_shutdown,
    output logic modulator_sample_clock,
    output logic avdd_monitor_en,
    output logic dvdd_monitor_en,
    output logic core_clock_en,
    output logic input_clock_en,
    output logic internal_ref_en,
    output logic full_shutdown
);
    import afe_pkg::*;

    // ==========================================================
    // Reset release

    // Reset takes hold at once but leaves on the clock, through two stages.
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // Configuration state

    logic [CFG_W-1:0] config_reg;
    logic [GAIN_W-1:0] gain_reg;
    logic [CHANNELS-1:0] ready_sticky;

    // Named slices of the configuration word.
    wire [3:0] shutdown_bits = config_reg[CFG_SHUTDOWN_LSB +: 4];
    wire [3:0] soft_reset_bits = config_reg[CFG_SOFT_RESET_LSB +: 4];
    wire ext_ref = config_reg[CFG_EXT_REF_BIT];
    wire ext_clk = config_reg[CFG_EXT_CLK_BIT];

    // ==========================================================
    // Power mode decode

    // Full shutdown needs every channel down and both externals chosen.
    wire next_full = (&shutdown_bits) & ext_ref & ext_clk;
    // Clearing any one of those bits brings the monitors straight back.
    wire next_monitors = ~next_full;
    // The core clock stops once no channel can convert.
    wire next_core_clk = ~(&(shutdown_bits | soft_reset_bits));
    // All channels down, which full shutdown implies, starves the inputs.
    wire next_input_clk = ~(&shutdown_bits);
    // The internal reference also rests whenever the external one is chosen.
    wire next_int_ref = ~ext_ref & ~next_full;

    // Supply monitors follow full shutdown alone.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_shutdown <= 1'b0;
            avdd_monitor_en <= 1'b1;
            dvdd_monitor_en <= 1'b1;
        end else begin
            full_shutdown <= next_full;
            avdd_monitor_en <= next_monitors;
            dvdd_monitor_en <= next_monitors;
        end
    end

    // Clock gates for the digital core and the input structure.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clock_en <= 1'b1;
            input_clock_en <= 1'b1;
        end else begin
            core_clock_en <= next_core_clk;
            input_clock_en <= next_input_clk;
        end
    end

    // Reference enable and per-channel shutdown flags.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_ref_en <= 1'b1;
            channel_shutdown <= '0;
        end else begin
            internal_ref_en <= next_int_ref;
            channel_shutdown <= shutdown_bits;
        end
    end

    // ==========================================================
    // Sample clock divider

    logic [SAMPLE_DIV_W-1:0] div_count;
    logic sample_tick;

    wire div_last = (div_count == SAMPLE_DIV_W'(SAMPLE_DIV - 1));
    // High for the first half of each period, low for the rest.
    wire div_high = (div_count < SAMPLE_DIV_W'(SAMPLE_DIV / 2));

    // The divider clears to zero while the core clock is off, so nothing toggles inside.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= '0;
        end else if (next_core_clk) begin
            div_count <= div_last ? '0 : div_count + 1'b1;
        end else begin
            div_count <= '0;
        end
    end

    // Tick and square wave are decoded from the count and stop with it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_tick <= 1'b0;
            modulator_sample_clock <= 1'b0;
        end else if (next_core_clk) begin
            sample_tick <= div_last;
            modulator_sample_clock <= div_high;
        end else begin
            sample_tick <= 1'b0;
            modulator_sample_clock <= 1'b0;
        end
    end

    // ==========================================================
    // Channels

    // Each channel talks to the top through its own interface instance.
    chan_if links[CHANNELS] ();
    logic [3:0] thermo_word [CHANNELS];
    logic signed [23:0] data_word [CHANNELS];
    logic [CHANNELS-1:0] ready_pulse;

    // All channels share one tick, so channels released from idle in the same cycle keep their windows in step.
    for (genvar g = 0; g < CHANNELS; g++) begin : gen_chan
        assign links[g].sample_tick = sample_tick;
        assign links[g].powered_down = shutdown_bits[g];
        assign links[g].soft_reset = soft_reset_bits[g];
        assign links[g].gain_code = gain_reg[3*g +: 3];
        assign links[g].sample = channel_sample[SAMPLE_W*g +: SAMPLE_W];
        assign thermo_word[g] = links[g].thermo;
        assign data_word[g] = links[g].data;
        assign ready_pulse[g] = links[g].data_ready;
        assign channel_thermo[4*g +: 4] = links[g].thermo;
        assign channel_data_ready[g] = links[g].data_ready;

        channel_modulator u_mod (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .link(links[g])
        );
    end

    // ==========================================================
    // APB decode

    // A transfer completes at the edge that sees psel, penable and pready.
    wire access = psel & penable;
    wire complete = access & pready;
    wire answer = access & ~pready;
    wire [7:0] word_addr = {paddr[7:2], 2'b00};
    wire [1:0] chan_sel = word_addr[3:2];

    // Data and range words repeat per channel at word steps.
    wire hit_config = (word_addr == OFS_CONFIG);
    wire hit_gain = (word_addr == OFS_GAIN);
    wire hit_status = (word_addr == OFS_STATUS);
    wire hit_thermo = (word_addr == OFS_THERMO);
    wire hit_ready = (word_addr == OFS_READY);
    wire hit_data = (word_addr[7:4] == OFS_DATA0[7:4]);
    wire hit_range = (word_addr[7:4] == OFS_RANGE0[7:4]);
    wire mapped = hit_config | hit_gain | hit_status | hit_thermo | hit_ready | hit_data | hit_range;

    // The bus ignores power state, so software can always leave shutdown.
    wire write_config = complete & pwrite & hit_config;
    wire write_gain = complete & pwrite & hit_gain;
    // Writing ones to the ready word clears those flags.
    wire write_ready = complete & pwrite & hit_ready;

    // Byte lanes merge into the stored word; the sticky clear looks at lane zero only.
    wire [31:0] config_word = {{(32-CFG_W){1'b0}}, config_reg};
    wire [31:0] gain_word = {{(32-GAIN_W){1'b0}}, gain_reg};
    wire [31:0] config_merged = apply_strb(config_word, pwdata, pstrb);
    wire [31:0] gain_merged = apply_strb(gain_word, pwdata, pstrb);
    wire [3:0] ready_clear = write_ready & pstrb[0] ? pwdata[3:0] : 4'h0;

    // ==========================================================
    // Read selection

    // The range halves per gain step; undefined codes read as gain one.
    wire [2:0] sel_shift = gain_shift(gain_reg[3*chan_sel +: 3]);
    wire [19:0] sel_range = RANGE_BASE_UV >> sel_shift;

    // Status bits sit at the package field positions.
    wire [31:0] status_word = (32'(next_full) << ST_FULL_SHUTDOWN)
                            | (32'(next_monitors) << ST_MONITORS)
                            | (32'(next_core_clk) << ST_CORE_CLOCK)
                            | (32'(next_input_clk) << ST_INPUT_CLOCK)
                            | (32'(next_int_ref) << ST_INT_REF);
    wire [31:0] thermo_all = {16'h0, thermo_word[3], thermo_word[2], thermo_word[1], thermo_word[0]};
    // Data reads are sign-extended to the full bus word.
    wire [31:0] data_sel = {{8{data_word[chan_sel][23]}}, data_word[chan_sel]};
    wire [31:0] range_sel = {12'h0, sel_range};

    // Unmapped addresses read as zero and raise the error flag.
    wire [31:0] read_word =
        hit_config ? config_word :
        hit_gain ? gain_word :
        hit_status ? status_word :
        hit_thermo ? thermo_all :
        hit_ready ? {28'h0, ready_sticky} :
        hit_data ? data_sel :
        hit_range ? range_sel : 32'h0000_0000;

    // ==========================================================
    // Bus response, one wait state

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= answer;
            pslverr <= answer & ~mapped;
        end
    end

    // Read data stands only in the answer cycle, zero otherwise.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (answer & ~pwrite) begin
            prdata <= read_word;
        end else begin
            prdata <= '0;
        end
    end

    // ==========================================================
    // Register updates

    // Power modes never touch these; only reset and writes do.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= CONFIG_RESET;
        end else if (write_config) begin
            config_reg <= config_merged[CFG_W-1:0];
        end
    end

    // Gain fields change only by a write.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_reg <= GAIN_RESET;
        end else if (write_gain) begin
            gain_reg <= gain_merged[GAIN_W-1:0];
        end
    end

    // A new data ready in the clearing cycle stays set.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_sticky <= '0;
        end else begin
            ready_sticky <= (ready_sticky & ~ready_clear) | ready_pulse;
        end
    end

endmodule // afe_power_and_gain_control

// ### core/chan_if.sv
// Control and result signals between the control top and one channel modulator.
`timescale 1ns/1ps
interface chan_if;
    logic sample_tick;
    logic powered_down;
    logic soft_reset;
    logic [2:0] gain_code;
    logic signed [15:0] sample;
    logic [3:0] thermo;
    logic signed [23:0] data;
    logic data_ready;

    modport ctrl (output sample_tick, powered_down, soft_reset, gain_code, sample,
                  input thermo, data, data_ready);
    modport chan (input sample_tick, powered_down, soft_reset, gain_code, sample,
                  output thermo, data, data_ready);
endinterface

// ### core/channel_modulator.sv
// Second-order five-level modulator model with a simple decimating accumulator.
`timescale 1ns/1ps
module channel_modulator (
    input wire logic ref_clk,
    input wire logic rst_n,
    chan_if.chan link
);
    import afe_pkg::*;

    logic signed [27:0] integ1;
    logic signed [27:0] integ2;
    logic [3:0] thermo;
    logic signed [9:0] acc;
    logic [OSR_W-1:0] osr_count;
    logic signed [23:0] data;
    logic data_ready;

    // ==========================================================
    // Gain and loop arithmetic
    wire [2:0] shift = gain_shift(link.gain_code);
    wire signed [27:0] sample_ext = {{12{link.sample[15]}}, link.sample};
    wire signed [27:0] scaled = sample_ext <<< shift;
    wire [2:0] ones = 3'(thermo[0]) + 3'(thermo[1]) + 3'(thermo[2]) + 3'(thermo[3]);
    wire signed [2:0] level = $signed(ones) - 3'sd2;
    wire signed [27:0] feedback = 28'(level * DAC_STEP);
    wire signed [27:0] next_integ1 = integ1 + scaled - feedback;
    wire signed [27:0] next_integ2 = integ2 + integ1 - feedback;
    wire signed [27:0] half = DAC_STEP >>> 1;
    wire signed [27:0] three_half = DAC_STEP + half;
    wire [3:0] next_thermo = {next_integ2 > three_half, next_integ2 > half,
                              next_integ2 > -half, next_integ2 > -three_half};
    wire signed [9:0] next_acc = acc + 10'(level);
    wire last = (osr_count == OSR_W'(OSR - 1));
    wire idle = link.powered_down | link.soft_reset;

    // ==========================================================
    // Loop state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            integ1 <= '0;
            integ2 <= '0;
            thermo <= THERMO_DEFAULT;
            acc <= '0;
            osr_count <= '0;
            data <= '0;
            data_ready <= 1'b0;
        end else if (idle) begin
            integ1 <= '0;
            integ2 <= '0;
            thermo <= THERMO_DEFAULT;
            acc <= '0;
            osr_count <= '0;
            data <= '0;
            data_ready <= 1'b0;
        end else if (link.sample_tick) begin
            integ1 <= next_integ1;
            integ2 <= next_integ2;
            thermo <= next_thermo;
            osr_count <= last ? '0 : osr_count + 1'b1;
            acc <= last ? '0 : next_acc;
            if (last) begin
                data <= 24'(next_acc) <<< 15;
            end
            data_ready <= last;
        end else begin
            data_ready <= 1'b0;
        end
    end

    assign link.thermo = thermo;
    assign link.data = data;
    assign link.data_ready = data_ready;

endmodule // channel_modulator

// ### verification/afe_ctrl_checker.sv
// Port assertions for the power mode and gain control block.
`timescale 1ns/1ps
module afe_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [afe_pkg::CHANNELS*4-1:0] channel_thermo,
    input wire logic [afe_pkg::CHANNELS-1:0] channel_data_ready,
    input wire logic [afe_pkg::CHANNELS-1:0] channel_shutdown,
    input wire logic modulator_sample_clock,
    input wire logic avdd_monitor_en,
    input wire logic dvdd_monitor_en,
    input wire logic core_clock_en,
    input wire logic input_clock_en,
    input wire logic internal_ref_en,
    input wire logic full_shutdown
);
    import afe_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_full_chan_off: assert property (
        full_shutdown |-> channel_shutdown == 4'hF)
        else $error("channel awake in full shutdown");
    chk_full_mon_off: assert property (
        full_shutdown |-> !avdd_monitor_en && !dvdd_monitor_en && !core_clock_en)
        else $error("monitor or core clock on in full shutdown");
    chk_full_in_clk: assert property (
        full_shutdown |-> !input_clock_en)
        else $error("input clock on in full shutdown");
    chk_full_ref_off: assert property (
        full_shutdown |-> !internal_ref_en)
        else $error("internal reference on in full shutdown");
    chk_mon_resume: assert property (
        !full_shutdown |-> avdd_monitor_en && dvdd_monitor_en)
        else $error("monitors off outside full shutdown");
    chk_msc_stopped: assert property (
        !core_clock_en && $past(!core_clock_en) |-> !modulator_sample_clock)
        else $error("sample clock runs with core clock off");
    chk_msc_low_time: assert property (
        @(posedge ref_clk) disable iff (!rstn || !core_clock_en)
        $fell(modulator_sample_clock) |=> !modulator_sample_clock[*8] ##1 !modulator_sample_clock
        ##1 modulator_sample_clock)
        else $error("sample clock low phase not ten cycles");
    chk_apb_one_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not after one wait state");
    chk_thermo_code: assert property (
        channel_thermo[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("quantizer output not a thermometer code");
    chk_sd_no_ready: assert property (
        !(|(channel_shutdown & $past(channel_shutdown) & channel_data_ready)))
        else $error("data ready from a shut down channel");
endmodule // afe_ctrl_checker

bind afe_power_and_gain_control afe_ctrl_checker i_afe_ctrl_checker (.ref_clk, .rstn, .psel, .penable,
    .pready, .channel_thermo, .channel_data_ready, .channel_shutdown, .modulator_sample_clock,
    .avdd_monitor_en, .dvdd_monitor_en, .core_clock_en, .input_clock_en, .internal_ref_en, .full_shutdown);

// ### verification/apb_host.sv
// Host model that issues one APB transfer per request.
`timescale 1ns/1ps
module apb_host (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic done,
    output logic err,
    output logic [31:0] rdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        done = 1'b0;
    end
    // Released address and data lines show the inverse so stale values never pass.
    always @(posedge ref_clk) begin
        done <= 1'b0;
        if (!psel && start && !done) begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end else if (psel && !penable) begin
            penable <= 1'b1;
        end else if (psel && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            err <= pslverr;
            rdata <= prdata;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end
    end
endmodule // apb_host

// ### verification/tb_afe_power_and_gain_control.sv
// Self-checking bench for the power mode and gain control block.
`timescale 1ns/1ps
module tb_afe_power_and_gain_control;
    import afe_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [63:0] sample = 64'h0;
    logic psel, penable, pwrite, pready, pslverr, done, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] thermo;
    logic [3:0] rdy, sd;
    logic msc, avdd, dvdd, core_en, in_en, ref_en, full;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;

    always #25 ref_clk = ~ref_clk;

    apb_host i_apb_host (.ref_clk(ref_clk), .start(start), .wr(wr), .addr(addr), .wdata(wdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done), .err(err), .rdata(rdata));

    afe_power_and_gain_control i_afe_power_and_gain_control (.ref_clk(ref_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_sample(sample),
        .channel_thermo(thermo), .channel_data_ready(rdy), .channel_shutdown(sd),
        .modulator_sample_clock(msc), .avdd_monitor_en(avdd), .dvdd_monitor_en(dvdd),
        .core_clock_en(core_en), .input_clock_en(in_en), .internal_ref_en(ref_en), .full_shutdown(full));

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        // This wait has no limit of its own; done or the bench timeout ends it.
        do begin
            @(negedge ref_clk);
        end while (done !== 1'b1);
        cmp(err, {31'h0, a == 8'h1C});
        @(posedge ref_clk);
        start <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp(rdata, exp);
    endtask

    task automatic t_reset();
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_STATUS, 32'h1E);
        cmp({full, avdd, dvdd, core_en, in_en, ref_en}, 32'h1F);
        xfer(1'b0, 8'h1C, 32'h0);
        cmp(err, 32'h1);
        cmp(rdata, 32'h0);
    endtask

    task automatic t_gain();
        int sh;
        for (int c = 0; c < 8; c++) begin
            sh = (c > 5) ? 0 : c;
            xfer(1'b1, OFS_GAIN, {20'h0, {4{c[2:0]}}});
            for (int n = 0; n < 4; n++) begin
                rd(OFS_RANGE0 + 8'(4 * n), 32'h927C0 >> sh);
            end
        end
        xfer(1'b1, OFS_GAIN, 32'h8D1);
        for (int n = 0; n < 4; n++) begin
            rd(OFS_RANGE0 + 8'(4 * n), 32'h927C0 >> (n + 1));
        end
    endtask

    task automatic t_full();
        int bits[6] = '{0, 1, 2, 3, 8, 9};
        xfer(1'b1, OFS_GAIN, 32'h29A);
        xfer(1'b1, OFS_CONFIG, 32'h30F);
        repeat (2) @(negedge ref_clk);
        cmp({full, avdd, dvdd, core_en, in_en, ref_en, sd}, 32'h20F);
        cmp(msc, 32'h0);
        rd(OFS_CONFIG, 32'h30F);
        rd(OFS_GAIN, 32'h29A);
        rd(OFS_STATUS, 32'h01);
        xfer(1'b1, OFS_GAIN, 32'h0);
        rd(OFS_GAIN, 32'h0);
        foreach (bits[i]) begin
            xfer(1'b1, OFS_CONFIG, 32'h30F & ~(32'h1 << bits[i]));
            repeat (2) @(negedge ref_clk);
            cmp({full, avdd, dvdd}, 32'h3);
            xfer(1'b1, OFS_CONFIG, 32'h30F);
            repeat (2) @(negedge ref_clk);
            cmp({full, avdd, dvdd}, 32'h4);
        end
        xfer(1'b1, OFS_CONFIG, 32'h0);
    endtask

    task automatic t_soft();
        xfer(1'b1, OFS_CONFIG, 32'hF0);
        repeat (2) @(negedge ref_clk);
        cmp(thermo, 32'h3333);
        rd(OFS_THERMO, 32'h3333);
        xfer(1'b1, OFS_READY, 32'hF);
        // Longer than one full decimation window of 64 ticks.
        repeat (1400) @(negedge ref_clk);
        rd(OFS_READY, 32'h0);
    endtask

    task automatic t_chan();
        sample <= {4{16'h1000}};
        xfer(1'b1, OFS_CONFIG, 32'h2);
        xfer(1'b1, OFS_READY, 32'hF);
        // Channels 0, 2 and 3 leave soft reset together, so their first pulses coincide.
        do begin
            @(negedge ref_clk);
        end while (rdy === 4'h0);
        cmp(rdy, 32'hD);
        rd(OFS_READY, 32'hD);
        rd(OFS_DATA0 + 8'h04, 32'h0);
        xfer(1'b1, OFS_CONFIG, 32'h0);
        xfer(1'b1, OFS_READY, 32'hF);
        repeat (2700) @(negedge ref_clk);
        rd(OFS_READY, 32'hF);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_gain();
        t_full();
        t_soft();
        t_chan();
        finish_test();
    end
endmodule // tb_afe_power_and_gain_control
